// file: rtl/anx_pkg.sv
// Package with register map, field positions, reset values and states.
package anx_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [3:0]  IDX_EXPANSION   = 4'h6;
    localparam logic [3:0]  IDX_NP_TX       = 4'h7;
    localparam logic [11:0] ADDR_EXPANSION  = 12'h018;
    localparam logic [11:0] ADDR_NP_TX      = 12'h01C;
    localparam logic [11:0] ADDR_CONFIG     = 12'h040;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h044;
    localparam logic [11:0] ADDR_IRQ_CLEAR  = 12'h048;
    localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h04C;
    localparam logic [11:0] ADDR_NP_STATUS  = 12'h050;

    // ------------------------------------------------------------------
    // Expansion register fields
    // ------------------------------------------------------------------
    localparam int EXP_BASE_PAGE  = 5;
    localparam int EXP_PD_FAULT   = 4;
    localparam int EXP_LP_NP_ABLE = 3;
    localparam int EXP_NP_ABLE    = 2;
    localparam int EXP_PAGE_RX    = 1;
    localparam int EXP_LP_AN_ABLE = 0;
    localparam logic LOCAL_NP_ABLE = 1'b1;

    // ------------------------------------------------------------------
    // Next-page transmit fields
    // ------------------------------------------------------------------
    localparam int NPT_MORE     = 15;
    localparam int NPT_RSVD     = 14;
    localparam int NPT_MSG      = 13;
    localparam int NPT_SECOND_ACKNOWLEDGE     = 12;
    localparam int NPT_TOGGLE   = 11;
    localparam int NPT_CODE_MSB = 10;
    localparam logic        NPT_MORE_RST   = 1'b0;
    localparam logic        NPT_MSG_RST    = 1'b1;
    localparam logic        NPT_SECOND_ACKNOWLEDGE_RST   = 1'b0;
    localparam logic        NPT_TOGGLE_RST = 1'b0;
    localparam logic [10:0] NPT_CODE_RST   = 11'h001;

    // ------------------------------------------------------------------
    // Configuration and interrupt layout
    // ------------------------------------------------------------------
    localparam int CFG_ALT_NP    = 0;
    localparam int IRQ_PAGE_RX   = 0;
    localparam int IRQ_PD_FAULT  = 1;
    localparam int IRQ_NP_SENT   = 2;
    localparam int IRQ_W         = 3;

    // Next-page hand-off states, Gray coded along the path.
    typedef enum logic [1:0] {
        ANX_IDLE    = 2'b00,
        ANX_PENDING = 2'b01,
        ANX_SENDING = 2'b11
    } anx_np_state_t;

endpackage

// file: rtl/anx_sticky.sv
// Bank of sticky event bits where a new event wins over a clear.
module anx_sticky
    import anx_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic [IRQ_W-1:0]   event_in,
    input  wire logic [IRQ_W-1:0]   clear_in,
    output logic      [IRQ_W-1:0]   flag
);

    // ------------------------------------------------------------------
    // One flop per event bit
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < IRQ_W; i++) begin : g_bit
            // Set beats clear so an event in the clearing cycle survives.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    flag[i] <= 1'b0;
                end else if (event_in[i]) begin
                    flag[i] <= 1'b1;
                end else if (clear_in[i]) begin
                    flag[i] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule

// file: rtl/anx_np_handoff.sv
// Hands the written next page to the arbitration logic, one page per write made while no page is pending.
module anx_np_handoff
    import anx_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        page_written,
    input  wire logic        np_ready,
    output logic             np_valid,
    output logic             np_sent
);

    anx_np_state_t state;
    anx_np_state_t next_state;

    // ------------------------------------------------------------------
    // State update
    // ------------------------------------------------------------------
    // A page is offered until the arbiter takes it, then reported sent.
    always_comb begin
        next_state = state;
        case (state)
            ANX_IDLE:    if (page_written) next_state = ANX_PENDING;
            ANX_PENDING: if (np_ready) next_state = ANX_SENDING;
            ANX_SENDING: next_state = page_written ? ANX_PENDING : ANX_IDLE;
            default:     next_state = ANX_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= ANX_IDLE;
            np_valid <= 1'b0;
            np_sent  <= 1'b0;
        end else begin
            state    <= next_state;
            np_valid <= (next_state == ANX_PENDING);
            np_sent  <= (next_state == ANX_SENDING);
        end
    end

endmodule

// file: rtl/anx_regs.sv
// Auto-negotiation expansion and next-page transmit registers on APB.
//
// Summary of operation
// (R1) Base page bit mirrors base page variable; only meaningful with alt NP.
// (R2) Parallel detection fault latches high until the register is read.
// (R3) Partner next page able bit follows the partner advertisement.
// (R4) Local next page able bit is read-only one.
// (R5) Page received sets after the received word is stored elsewhere.
// (R6) Reading the expansion register clears page received.
// (R7) With alt NP, page received also clears on variable false or tx off.
// (R8) Partner auto-negotiation able bit follows detection result.
// (R9) More-pages flag is writable, zero after reset.
// (R10) Reserved transmit bit reads zero and ignores writes.
// (R11) Message page flag is writable, one after reset.
// (R12) Second acknowledge flag is writable, zero after reset.
// (R13) Toggle flag is writable, holds the inverse of previous toggle; the code stores whatever value is written.
// (R14) Written transmit page, code field included, is offered as next page.
module anx_regs
    import anx_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        base_page_var,
    input  wire logic        pd_fault_event,
    input  wire logic        lp_np_able,
    input  wire logic        page_rx_event,
    input  wire logic        page_received_variable,
    input  wire logic        transmit_disable,
    input  wire logic        lp_an_able,
    input  wire logic        np_ready,
    output logic             np_valid,
    output logic      [15:0] np_word,
    output logic             alt_np_enable,
    output logic             irq
);

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic        acc;
    logic        wr;
    logic        rd;
    logic        hit;
    logic        rd_exp;
    logic        wr_npt;
    logic        wr_lo;
    logic        wr_hi;
    logic [31:0] next_rdata;

    // The slave always answers in the access cycle; pready is registered from the setup cycle.
    assign acc    = psel && penable;
    assign wr     = acc && pwrite;
    assign rd     = acc && !pwrite;
    assign hit    = (paddr == ADDR_EXPANSION) || (paddr == ADDR_NP_TX)
                 || (paddr == ADDR_CONFIG) || (paddr == ADDR_IRQ_STATUS)
                 || (paddr == ADDR_IRQ_CLEAR) || (paddr == ADDR_IRQ_ENABLE)
                 || (paddr == ADDR_NP_STATUS);
    assign rd_exp = rd && (paddr == ADDR_EXPANSION);
    assign wr_npt = wr && (paddr == ADDR_NP_TX);
    assign wr_lo  = pstrb[0];
    assign wr_hi  = pstrb[1];

    // ------------------------------------------------------------------
    // Expansion status bits
    // ------------------------------------------------------------------
    logic pd_fault;
    logic page_rx;
    logic page_var_q;
    logic tx_dis_q;
    logic page_var_fell;
    logic tx_dis_rose;

    // Edges of the variables; the clear acts on the transition only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_var_q <= 1'b0;
            tx_dis_q   <= 1'b0;
        end else begin
            page_var_q <= page_received_variable;
            tx_dis_q   <= transmit_disable;
        end
    end

    assign page_var_fell = page_var_q && !page_received_variable;
    assign tx_dis_rose   = !tx_dis_q && transmit_disable;

    // Fault latches high. A read clears only a bit that it reported, so
    // a fault that lands after the setup capture is not lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd_fault <= 1'b0;
        end else if (pd_fault_event) begin
            pd_fault <= 1'b1;                                  // [R2]
        end else if (rd_exp && prdata[EXP_PD_FAULT]) begin
            pd_fault <= 1'b0;                                  // [R2]
        end
    end

    // Page received: set wins over both read clear and variable clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_rx <= 1'b0;
        end else if (page_rx_event) begin
            page_rx <= 1'b1;                                   // [R5]
        end else if (rd_exp && prdata[EXP_PAGE_RX]) begin
            page_rx <= 1'b0;                                   // [R6]
        end else if (alt_np_enable && (page_var_fell || tx_dis_rose)) begin
            page_rx <= 1'b0;                                   // [R7]
        end
    end

    // ------------------------------------------------------------------
    // Next-page transmit register
    // ------------------------------------------------------------------
    logic        npt_more;
    logic        npt_msg;
    logic        npt_second_acknowledge;
    logic        npt_toggle;
    logic [10:0] npt_code;

    // Byte lanes: low byte holds code bits 7:0, high byte the flags and code bits 10:8.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            npt_more   <= NPT_MORE_RST;
            npt_msg    <= NPT_MSG_RST;
            npt_second_acknowledge   <= NPT_SECOND_ACKNOWLEDGE_RST;
            npt_toggle <= NPT_TOGGLE_RST;
            npt_code   <= NPT_CODE_RST;
        end else if (wr_npt) begin
            if (wr_hi) begin
                npt_more      <= pwdata[NPT_MORE];             // [R9]
                npt_msg       <= pwdata[NPT_MSG];              // [R11]
                npt_second_acknowledge      <= pwdata[NPT_SECOND_ACKNOWLEDGE];             // [R12]
                npt_toggle    <= pwdata[NPT_TOGGLE];           // [R13]
                npt_code[10:8] <= pwdata[NPT_CODE_MSB:8];
            end
            if (wr_lo) begin
                npt_code[7:0] <= pwdata[7:0];
            end
        end
    end

    // Reserved bit is simply not stored, so it always reads zero.
    logic [15:0] npt_value;
    assign npt_value = {npt_more, 1'b0, npt_msg, npt_second_acknowledge,     // [R10]
                        npt_toggle, npt_code};

    // Word is captured at each write, so it changes only when a new page is written.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            np_word <= 16'h0000;
        end else if (wr_npt) begin
            np_word <= npt_value_next();                       // [R14]
        end
    end

    // Value the register will hold after the current write.
    function automatic logic [15:0] npt_value_next();
        logic [15:0] v;
        v = npt_value;
        if (wr_hi) begin
            v[15:8] = pwdata[15:8];
        end
        if (wr_lo) begin
            v[7:0] = pwdata[7:0];
        end
        v[NPT_RSVD] = 1'b0;
        return v;
    endfunction

    logic np_sent;

    // The offer comes straight from the hand-off flop; a registered copy
    // would stay high for a cycle after the arbiter took the page.
    anx_np_handoff u_handoff (
        .pclk         (pclk),
        .presetn      (presetn),
        .page_written (wr_npt),
        .np_ready     (np_ready),
        .np_valid     (np_valid),                              // [R14]
        .np_sent      (np_sent)
    );

    // ------------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------------
    // Bit 0 arms the edge clears of page received.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_np_enable <= 1'b0;
        end else if (wr && (paddr == ADDR_CONFIG) && wr_lo) begin
            alt_np_enable <= pwdata[CFG_ALT_NP];
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic [IRQ_W-1:0] irq_event;
    logic [IRQ_W-1:0] irq_clear;

    // Event sources, one sticky status bit each.
    assign irq_event[IRQ_PAGE_RX]  = page_rx_event;
    assign irq_event[IRQ_PD_FAULT] = pd_fault_event;
    assign irq_event[IRQ_NP_SENT]  = np_sent;
    assign irq_clear = (wr && (paddr == ADDR_IRQ_CLEAR) && wr_lo)
                     ? pwdata[IRQ_W-1:0] : '0;

    anx_sticky u_sticky (
        .pclk     (pclk),
        .presetn  (presetn),
        .event_in (irq_event),
        .clear_in (irq_clear),
        .flag     (irq_status)
    );

    // Enable mask; a masked event still sets its status bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable <= '0;
        end else if (wr && (paddr == ADDR_IRQ_ENABLE) && wr_lo) begin
            irq_enable <= pwdata[IRQ_W-1:0];
        end
    end

    // Registered, so irq trails the status bit by one cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_enable);
        end
    end

    // ------------------------------------------------------------------
    // Read mux and response
    // ------------------------------------------------------------------
    // Read data is registered in the setup cycle so it is valid at access.
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (paddr)
            ADDR_EXPANSION: begin
                next_rdata[EXP_BASE_PAGE]  = base_page_var;    // [R1]
                next_rdata[EXP_PD_FAULT]   = pd_fault;         // [R2]
                next_rdata[EXP_LP_NP_ABLE] = lp_np_able;       // [R3]
                next_rdata[EXP_NP_ABLE]    = LOCAL_NP_ABLE;    // [R4]
                next_rdata[EXP_PAGE_RX]    = page_rx;          // [R5]
                next_rdata[EXP_LP_AN_ABLE] = lp_an_able;       // [R8]
            end
            ADDR_NP_TX:      next_rdata[15:0] = npt_value;
            ADDR_CONFIG:     next_rdata[CFG_ALT_NP] = alt_np_enable;
            ADDR_IRQ_STATUS: next_rdata[IRQ_W-1:0] = irq_status;
            ADDR_IRQ_ENABLE: next_rdata[IRQ_W-1:0] = irq_enable;
            ADDR_NP_STATUS:  next_rdata[0] = np_valid;
            default:         next_rdata = 32'h0000_0000;
        endcase
    end

    // One access cycle, no wait states; the held read data tells the
    // latch clears which bits software has seen.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            if (psel && !penable && !pwrite) begin
                prdata <= next_rdata;
            end
        end
    end

endmodule

// file: tb/anx_regs_sva.sv
// Checker for the expansion and next-page transmit register block.
module anx_regs_sva
    import anx_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        base_page_var,
    input wire logic        pd_fault_event,
    input wire logic        lp_np_able,
    input wire logic        page_rx_event,
    input wire logic        page_received_variable,
    input wire logic        transmit_disable,
    input wire logic        lp_an_able,
    input wire logic        np_valid,
    input wire logic [15:0] np_word,
    input wire logic        alt_np_enable,
    input wire logic        np_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rd_set, rd_acc, np_wr, bad_adr, seen_pd, seen_pg;
    // -----------------------------------------------------------------
    // Decode helpers
    // -----------------------------------------------------------------
    // Bus phase decodes shared by the properties below.
    assign rd_set  = psel && !penable && !pwrite && paddr == ADDR_EXPANSION;
    assign rd_acc  = psel && penable && !pwrite && paddr == ADDR_EXPANSION;
    assign np_wr   = psel && penable && pwrite && paddr == ADDR_NP_TX;
    assign bad_adr = !(paddr inside {ADDR_EXPANSION, ADDR_NP_TX, ADDR_CONFIG,
        ADDR_IRQ_STATUS, ADDR_IRQ_CLEAR, ADDR_IRQ_ENABLE, ADDR_NP_STATUS});
    // Expected latched bits; a read clears only what it reported and a
    // new event wins over any clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_pd <= 1'b0;
            seen_pg <= 1'b0;
        end else begin
            seen_pd <= pd_fault_event
                || (seen_pd && !(rd_acc && prdata[EXP_PD_FAULT]));
            seen_pg <= page_rx_event || (seen_pg
                && !(rd_acc && prdata[EXP_PAGE_RX]) && !(alt_np_enable
            && ($fell(page_received_variable) || $rose(transmit_disable))));
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // -----------------------------------------------------------------
    // Properties
    // -----------------------------------------------------------------
    pready_timing_a: assert property (psel && !penable |=> pready)
        else $error("no pready after setup");
    pready_scope_a: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    slverr_map_a: assert property (
        psel && !penable |=> pslverr == $past(bad_adr))
        else $error("pslverr does not match decode");
    np_able_a: assert property (
        rd_set |=> prdata[EXP_NP_ABLE] && prdata[31:6] == 26'h0000000)
        else $error("local ability or reserved bits wrong");
    lp_ability_a: assert property (rd_set |=>
        prdata[EXP_LP_NP_ABLE] == $past(lp_np_able) &&
        prdata[EXP_LP_AN_ABLE] == $past(lp_an_able))
        else $error("partner ability bits wrong");
    base_page_a: assert property (
        rd_set && alt_np_enable |=>
        prdata[EXP_BASE_PAGE] == $past(base_page_var))
        else $error("base page bit wrong");
    fault_latch_a: assert property (
        rd_set |=> prdata[EXP_PD_FAULT] == $past(seen_pd))
        else $error("fault latch wrong");
    page_latch_a: assert property (
        rd_set |=> prdata[EXP_PAGE_RX] == $past(seen_pg))
        else $error("page received latch wrong");
    np_word_a: assert property (np_wr && pstrb == 4'hF |=>
        np_word == {$past(pwdata[15]), 1'b0, $past(pwdata[13:0])})
        else $error("page word not loaded");
    np_valid_a: assert property (np_wr && !np_valid |=> np_valid)
        else $error("page not offered");
    np_hold_a: assert property (np_valid && !np_ready |=> np_valid)
        else $error("page offer dropped early");
    np_take_a: assert property (np_valid && np_ready |=> !np_valid)
        else $error("page still offered after it was taken");
endmodule

bind anx_regs anx_regs_sva i_anx_regs_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .base_page_var(base_page_var), .pd_fault_event(pd_fault_event),
    .lp_np_able(lp_np_able), .page_rx_event(page_rx_event),
    .page_received_variable(page_received_variable),
    .transmit_disable(transmit_disable), .lp_an_able(lp_an_able),
    .np_valid(np_valid), .np_word(np_word), .alt_np_enable(alt_np_enable),
    .np_ready(np_ready)
);

// file: tb/anx_regs_bench.sv
// Self-checking bench for the expansion and next-page register block.
module anx_regs_bench
    import anx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic        base_page_var, pd_fault_event, lp_np_able, page_rx_event;
    logic        page_received_variable, transmit_disable, lp_an_able;
    logic        np_ready, np_valid, alt_np_enable;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic [15:0] np_word;
    int          n_mismatch, total_checks;

    anx_regs i_anx_regs (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .base_page_var(base_page_var), .pd_fault_event(pd_fault_event),
        .lp_np_able(lp_np_able), .page_rx_event(page_rx_event),
        .page_received_variable(page_received_variable),
        .transmit_disable(transmit_disable), .lp_an_able(lp_an_able),
        .np_ready(np_ready), .np_valid(np_valid), .np_word(np_word),
        .alt_np_enable(alt_np_enable), .irq(irq));

    // 25 MHz clock.
    always #20 pclk = ~pclk;
    // -----------------------------------------------------------------
    // Shared tasks
    // -----------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask
    // One APB transfer; the request stands until pready is seen at an edge.
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        if (pready !== 1'b1) begin
            n_mismatch++;
            $display("wrong value at %0t: bus hang", $time);
            end_sim();
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        chk({31'h0, e}, 32'h0, "write error");
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x,
                      input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x, "read data");
        chk({31'h0, e}, {31'h0, xe}, "error flag");
    endtask
    task automatic pulse(input logic pd, input logic pg);
        @(posedge pclk);
        pd_fault_event <= pd;
        page_rx_event  <= pg;
        @(posedge pclk);
        pd_fault_event <= 1'b0;
        page_rx_event  <= 1'b0;
        repeat (3) @(negedge pclk);
    endtask
    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    task automatic t_regs();
        rd(ADDR_NP_TX, 32'h00002001, 1'b0);
        rd(ADDR_EXPANSION, 32'h00000004, 1'b0);
        wr(ADDR_EXPANSION, 32'h0000FFFF);
        rd(ADDR_EXPANSION, 32'h00000004, 1'b0);
        rd(12'h020, 32'h00000000, 1'b1);
        wr(ADDR_CONFIG, 32'h00000001);
        @(posedge pclk);
        lp_np_able    <= 1'b1;
        lp_an_able    <= 1'b1;
        base_page_var <= 1'b1;
        rd(ADDR_EXPANSION, 32'h0000002D, 1'b0);
        @(posedge pclk);
        lp_np_able    <= 1'b0;
        lp_an_able    <= 1'b0;
        base_page_var <= 1'b0;
        rd(ADDR_EXPANSION, 32'h00000004, 1'b0);
        $display("test registers done");
    endtask
    // Events latch, interrupt raised, cleared and masked.
    task automatic t_events();
        wr(ADDR_IRQ_ENABLE, 32'h00000003);
        pulse(1'b1, 1'b1);
        chk({31'h0, irq}, 32'h1, "irq raised");
        rd(ADDR_IRQ_STATUS, 32'h00000003, 1'b0);
        rd(ADDR_EXPANSION, 32'h00000016, 1'b0);
        rd(ADDR_EXPANSION, 32'h00000004, 1'b0);
        wr(ADDR_IRQ_CLEAR, 32'h00000003);
        repeat (2) @(negedge pclk);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        wr(ADDR_IRQ_ENABLE, 32'h00000000);
        pulse(1'b1, 1'b0);
        chk({31'h0, irq}, 32'h0, "irq masked");
        rd(ADDR_IRQ_STATUS, 32'h00000002, 1'b0);
        rd(ADDR_EXPANSION, 32'h00000014, 1'b0);
        $display("test events done");
    endtask
    // Page received cleared by the variable edges only with the alt mode.
    task automatic t_alt();
        page_received_variable <= 1'b1;
        pulse(1'b0, 1'b1);
        @(posedge pclk) page_received_variable <= 1'b0;
        repeat (3) @(posedge pclk);
        rd(ADDR_EXPANSION, 32'h00000004, 1'b0);
        pulse(1'b0, 1'b1);
        @(posedge pclk) transmit_disable <= 1'b1;
        repeat (3) @(posedge pclk);
        rd(ADDR_EXPANSION, 32'h00000004, 1'b0);
        transmit_disable <= 1'b0;
        wr(ADDR_CONFIG, 32'h00000000);
        page_received_variable <= 1'b1;
        pulse(1'b0, 1'b1);
        @(posedge pclk) page_received_variable <= 1'b0;
        repeat (3) @(posedge pclk);
        rd(ADDR_EXPANSION, 32'h00000006, 1'b0);
        $display("test alternate mode done");
    endtask
    // Each of the three pages in v is offered, taken and flagged in the status.
    task automatic t_np();
        logic [31:0] v [3] = '{32'h0000FFFF, 32'h00000800, 32'h00005555};
        int i;
        wr(ADDR_IRQ_CLEAR, 32'h00000007);
        foreach (v[k]) begin
            wr(ADDR_NP_TX, v[k]);
            @(negedge pclk);
            chk({16'h0, np_word}, v[k] & 32'h0000BFFF, "word");
            for (i = 0; i < 16 && np_valid !== 1'b1; i++) @(negedge pclk);
            chk({31'h0, np_valid}, 32'h1, "page offered");
            rd(ADDR_NP_STATUS, 32'h00000001, 1'b0);
            @(posedge pclk);
            np_ready <= 1'b1;
            @(posedge pclk);
            np_ready <= 1'b0;
            repeat (3) @(negedge pclk);
            chk({31'h0, np_valid}, 32'h0, "page taken");
            rd(ADDR_NP_TX, v[k] & 32'h0000BFFF, 1'b0);
            rd(ADDR_IRQ_STATUS, 32'h00000004, 1'b0);
            wr(ADDR_IRQ_CLEAR, 32'h00000004);
        end
        pstrb <= 4'h1;
        wr(ADDR_NP_TX, 32'h0000FFAA);
        rd(ADDR_NP_TX, 32'h000015AA, 1'b0);
        $display("test next page done");
    endtask

    initial begin
        {pclk, presetn, psel, penable, pwrite, base_page_var} = '0;
        {pd_fault_event, lp_np_able, page_rx_event, lp_an_able} = '0;
        {page_received_variable, transmit_disable, np_ready} = '0;
        {paddr, pwdata} = '0;
        pstrb = 4'hF;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_events();
        t_alt();
        t_np();
        end_sim();
    end
    // Hang guard for the whole run.
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        $display("wrong value at %0t: run timeout", $time);
        end_sim();
    end
endmodule
